// ===== rtl/pdc_top.sv
// PECL channel dividers: register file on Avalon-MM and two dividers
`include "pdc_defs.svh"

module pdc_top (
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire logic [8:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  input  wire logic              align_n,
  input  wire logic              vco_level,
  input  wire logic              ref_level,
  output logic                   pecl_out_a0,
  output logic                   pecl_out_a1,
  output logic                   pecl_out_b0,
  output logic                   pecl_out_b1
);
  import pdc_pkg::*;

  localparam int NDIV = `PDC_NUM_DIV;

  logic               rst_s1_reg;
  logic               rst_n;
  pdc_pins_s          pins_raw;
  pdc_pins_s          pins;
  logic               align_active;

  pdc_cfg_s           cfg_reg   [NDIV];
  pdc_cfg_s           cfg_next  [NDIV];
  logic [7:0]         insel_reg;
  logic [7:0]         insel_next;
  logic               wait_reg;
  logic               wait_next;
  logic [31:0]        rdata_reg;
  logic [31:0]        rdata_next;
  logic [7:0]         rd_byte;
  logic [1:0]         in_sel;

  logic [NDIV-1:0]    div_out_reg;
  logic [NDIV-1:0]    div_running;

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_reg <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n      <= rst_s1_reg;
    end
  end

  // Pins arrive from outside the clock domain
  assign pins_raw.align_n = align_n;
  assign pins_raw.vco_lvl = vco_level;
  assign pins_raw.ref_lvl = ref_level;

  pdc_pin_sync u_pin_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .pins_in  (pins_raw),
    .pins_out (pins)
  );

  assign align_active = ~pins.align_n;
  assign in_sel       = insel_reg[`PDC_SEL_MSB:`PDC_SEL_LSB];

  // Read mux; unmapped addresses read zero
  // Status shows live state, so two reads in a row may differ
  always_comb begin
    case (avs_address)
      `PDC_OFF_A_CYCLES:  rd_byte = cfg_reg[0].cycles;
      `PDC_OFF_A_CONTROL: rd_byte = cfg_reg[0].control;
      `PDC_OFF_A_ROUTING: rd_byte = cfg_reg[0].routing;
      `PDC_OFF_B_CYCLES:  rd_byte = cfg_reg[1].cycles;
      `PDC_OFF_B_CONTROL: rd_byte = cfg_reg[1].control;
      `PDC_OFF_B_ROUTING: rd_byte = cfg_reg[1].routing;
      `PDC_OFF_IN_SELECT: rd_byte = insel_reg;
      `PDC_OFF_STATUS:    rd_byte = {3'h0, div_running, div_out_reg, align_active};
      default:            rd_byte = 8'h00;
    endcase
  end

  // Bus slave: one wait cycle, then the access completes
  // Every access costs two cycles; no other back-pressure
  always_comb begin
    wait_next  = 1'b1;
    rdata_next = rdata_reg;
    insel_next = insel_reg;
    for (int i = 0; i < NDIV; i++) begin
      cfg_next[i] = cfg_reg[i];
    end
    if ((avs_read || avs_write) && wait_reg) begin
      wait_next = 1'b0;
      if (avs_read) begin
        rdata_next = {24'h000000, rd_byte};
      end
    end
    // Write lands on the edge where waitrequest is seen low
    if (avs_write && !wait_reg) begin
      case (avs_address)
        `PDC_OFF_A_CYCLES:  cfg_next[0].cycles  = avs_writedata[7:0];
        `PDC_OFF_A_CONTROL: cfg_next[0].control = avs_writedata[7:0];
        `PDC_OFF_A_ROUTING: cfg_next[0].routing = avs_writedata[7:0];
        `PDC_OFF_B_CYCLES:  cfg_next[1].cycles  = avs_writedata[7:0];
        `PDC_OFF_B_CONTROL: cfg_next[1].control = avs_writedata[7:0];
        `PDC_OFF_B_ROUTING: cfg_next[1].routing = avs_writedata[7:0];
        `PDC_OFF_IN_SELECT: insel_next = avs_writedata[7:0];
        default: ;
      endcase
    end
  end

  // Register file and bus handshake
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_reg  <= 1'b1;
      rdata_reg <= 32'h00000000;
      insel_reg <= `PDC_RST_IN_SELECT;
      for (int i = 0; i < NDIV; i++) begin
        cfg_reg[i].cycles  <= `PDC_RST_CYCLES;
        cfg_reg[i].control <= `PDC_RST_CONTROL;
        cfg_reg[i].routing <= `PDC_RST_ROUTING;
      end
    end else begin
      wait_reg  <= wait_next;
      rdata_reg <= rdata_next;
      insel_reg <= insel_next;
      for (int i = 0; i < NDIV; i++) begin
        cfg_reg[i] <= cfg_next[i];
      end
    end
  end

  assign avs_waitrequest = wait_reg;
  assign avs_readdata    = rdata_reg;

  // One divider per channel
  for (genvar gi = 0; gi < NDIV; gi++) begin : g_div
    pdc_state_e  state_reg;
    pdc_state_e  state_next;
    logic [4:0]  cnt_reg;
    logic [4:0]  cnt_next;
    logic        lvl_reg;
    logic        lvl_next;
    logic        out_next;
    logic [4:0]  lo_raw;
    logic [4:0]  hi_raw;
    logic [4:0]  sum;
    logic [4:0]  hi_dcc;
    logic [4:0]  lo_n;
    logic [4:0]  hi_n;
    logic [3:0]  phase;
    logic        bypass;
    logic        nosync;
    logic        force_lvl;
    logic        start_lvl;
    logic        direct;
    logic        hold;
    logic        div_lvl;

    // Field decode and effective half-period counts
    always_comb begin
      bypass    = cfg_reg[gi].control[`PDC_BIT_BYPASS];
      nosync    = cfg_reg[gi].control[`PDC_BIT_NOSYNC];
      force_lvl = cfg_reg[gi].control[`PDC_BIT_FORCE];
      start_lvl = cfg_reg[gi].control[`PDC_BIT_START];
      phase     = cfg_reg[gi].control[`PDC_PHASE_MSB:`PDC_PHASE_LSB];
      direct    = cfg_reg[gi].routing[`PDC_BIT_DIRECT];
      // Zero would stall the counter, so it counts as one cycle
      lo_raw = {1'b0, cfg_reg[gi].cycles[`PDC_LOW_MSB:`PDC_LOW_LSB]};
      hi_raw = {1'b0, cfg_reg[gi].cycles[`PDC_HIGH_MSB:`PDC_HIGH_LSB]};
      if (lo_raw == 5'h00) begin
        lo_raw = `PDC_MIN_CYCLES;
      end
      if (hi_raw == 5'h00) begin
        hi_raw = `PDC_MIN_CYCLES;
      end
      sum    = lo_raw + hi_raw;
      hi_dcc = 5'((sum + 5'h01) >> 1);
      // Correction splits the period evenly; odd periods favour high
      if (!cfg_reg[gi].routing[`PDC_BIT_DUTY_OFF]) begin
        hi_n = hi_dcc;
        lo_n = sum - hi_dcc;
      end else begin
        hi_n = hi_raw;
        lo_n = lo_raw;
      end
      hold = align_active && !nosync;
    end

    // Sequencer: hold, phase delay, then free division
    always_comb begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      lvl_next   = lvl_reg;
      if (bypass || nosync || hold) begin
        state_next = PDC_ST_HOLD;
        lvl_next   = start_lvl;
        cnt_next   = 5'h00;
      end else begin
        case (state_reg)
          PDC_ST_HOLD: begin
            lvl_next = start_lvl;
            if (phase == 4'h0) begin
              state_next = PDC_ST_RUN;
              cnt_next   = start_lvl ? hi_n : lo_n;
            end else begin
              state_next = PDC_ST_PHASE;
              cnt_next   = {1'b0, phase};
            end
          end
          PDC_ST_PHASE: begin
            if (cnt_reg <= 5'h01) begin
              state_next = PDC_ST_RUN;
              cnt_next   = start_lvl ? hi_n : lo_n;
            end else begin
              cnt_next = cnt_reg - 5'h01;
            end
          end
          PDC_ST_RUN: begin
            // Flip level when the current half period is used up
            if (cnt_reg <= 5'h01) begin
              lvl_next = ~lvl_reg;
              cnt_next = lvl_reg ? lo_n : hi_n;
            end else begin
              cnt_next = cnt_reg - 5'h01;
            end
          end
          default: begin
            state_next = PDC_ST_HOLD;
            cnt_next   = 5'h00;
          end
        endcase
      end
    end

    // Output selection; bypass shows the input clock as a toggle
    always_comb begin
      if (bypass) begin
        div_lvl = ~div_out_reg[gi];
      end else if (nosync) begin
        div_lvl = force_lvl;
      end else if (state_reg == PDC_ST_RUN) begin
        div_lvl = lvl_reg;
      end else begin
        div_lvl = start_lvl;
      end
      if (direct && in_sel == `PDC_SEL_VCO) begin
        out_next = pins.vco_lvl;
      end else if (direct && in_sel == `PDC_SEL_REF) begin
        out_next = pins.ref_lvl;
      end else begin
        out_next = div_lvl;
      end
    end

    // Divider state registers
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        state_reg       <= PDC_ST_HOLD;
        cnt_reg         <= 5'h00;
        lvl_reg         <= 1'b0;
        div_out_reg[gi] <= 1'b0;
      end else begin
        state_reg       <= state_next;
        cnt_reg         <= cnt_next;
        lvl_reg         <= lvl_next;
        div_out_reg[gi] <= out_next;
      end
    end

    assign div_running[gi] = (state_reg == PDC_ST_RUN);
  end

  // Each divider drives both outputs of its pair
  // One flop per pair keeps the two pins of a pair free of skew
  assign pecl_out_a0 = div_out_reg[0];
  assign pecl_out_a1 = div_out_reg[0];
  assign pecl_out_b0 = div_out_reg[1];
  assign pecl_out_b1 = div_out_reg[1];

endmodule

// ===== rtl/pdc_defs.svh
// Register offsets, field positions, reset values and counts of the PECL divider block
`ifndef PDC_DEFS_SVH
`define PDC_DEFS_SVH

// Register word indexes (byte address is four times the index)
`define PDC_OFF_A_CYCLES   9'h190
`define PDC_OFF_A_CONTROL  9'h191
`define PDC_OFF_A_ROUTING  9'h192
`define PDC_OFF_B_CYCLES   9'h193
`define PDC_OFF_B_CONTROL  9'h194
`define PDC_OFF_B_ROUTING  9'h195
`define PDC_OFF_IN_SELECT  9'h1e1
`define PDC_OFF_STATUS     9'h1f0

// Cycle-count register fields
`define PDC_LOW_MSB        7
`define PDC_LOW_LSB        4
`define PDC_HIGH_MSB       3
`define PDC_HIGH_LSB       0

// Control register fields
`define PDC_BIT_BYPASS     7
`define PDC_BIT_NOSYNC     6
`define PDC_BIT_FORCE      5
`define PDC_BIT_START      4
`define PDC_PHASE_MSB      3
`define PDC_PHASE_LSB      0

// Routing register fields
`define PDC_BIT_DIRECT     1
`define PDC_BIT_DUTY_OFF   0

// Input-select field and its codes
`define PDC_SEL_MSB        1
`define PDC_SEL_LSB        0
`define PDC_SEL_VCO        2'h2
`define PDC_SEL_REF        2'h0

// Reset values
`define PDC_RST_CYCLES     8'h11
`define PDC_RST_CONTROL    8'h00
`define PDC_RST_ROUTING    8'h00
`define PDC_RST_IN_SELECT  8'h00
`define PDC_RST_PINS       3'h1

// Counts
`define PDC_NUM_DIV        2
`define PDC_MIN_CYCLES     5'h01

`endif

// ===== rtl/pdc_pkg.sv
// Types shared by the PECL divider block
package pdc_pkg;

  // Configuration of one divider, one byte per register
  typedef struct packed {
    logic [7:0] cycles;
    logic [7:0] control;
    logic [7:0] routing;
  } pdc_cfg_s;

  // Divider sequencing states
  typedef enum logic [2:0] {
    PDC_ST_HOLD  = 3'b001,
    PDC_ST_PHASE = 3'b010,
    PDC_ST_RUN   = 3'b100
  } pdc_state_e;

  // Synchronised pin levels
  typedef struct packed {
    logic ref_lvl;
    logic vco_lvl;
    logic align_n;
  } pdc_pins_s;

endpackage

// ===== rtl/pdc_pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`include "pdc_defs.svh"

module pdc_pin_sync (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  pdc_pkg::pdc_pins_s     pins_in,
  output pdc_pkg::pdc_pins_s     pins_out
);
  import pdc_pkg::*;

  logic [2:0] s1_reg;
  logic [2:0] s2_reg;
  logic [2:0] s3_reg;
  logic [2:0] filt_reg;
  logic [2:0] filt_next;
  logic [2:0] agree;

  // A change counts only once stages two and three agree
  always_comb begin
    agree     = ~(s2_reg ^ s3_reg);
    filt_next = (s3_reg & agree) | (filt_reg & ~agree);
  end

  // First stage feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg   <= `PDC_RST_PINS;
      s2_reg   <= `PDC_RST_PINS;
      s3_reg   <= `PDC_RST_PINS;
      filt_reg <= `PDC_RST_PINS;
    end else begin
      s1_reg   <= pins_in;
      s2_reg   <= s1_reg;
      s3_reg   <= s2_reg;
      filt_reg <= filt_next;
    end
  end

  assign pins_out = filt_reg;

endmodule

// ===== testbench/pdc_checker.sv
// Checker of bus timing and output pin relations of the PECL dividers
module pdc_checker (
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic [8:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        vco_level,
  input wire logic        ref_level,
  input wire logic        pecl_out_a0,
  input wire logic        pecl_out_a1,
  input wire logic        pecl_out_b0,
  input wire logic        pecl_out_b1
);
  logic [7:0] ctl_reg, ctl_next, rte_reg, rte_next;
  logic [1:0] sel_reg, sel_next;
  logic [3:0] age_reg, age_next;
  logic       wr, ok, dir;

  // Accepted writes; pins get eight quiet cycles to settle after one
  assign wr  = avs_write && !avs_waitrequest;
  assign ok  = age_reg[3];
  assign dir = rte_reg[1] && !sel_reg[0];

  // Shadow of divider A setup and the input select
  always_comb begin
    ctl_next = ctl_reg;
    rte_next = rte_reg;
    sel_next = sel_reg;
    age_next = age_reg[3] ? age_reg : age_reg + 4'h1;
    if (wr) age_next = 4'h0;
    if (wr && avs_address == 9'h191) ctl_next = avs_writedata[7:0];
    if (wr && avs_address == 9'h192) rte_next = avs_writedata[7:0];
    if (wr && avs_address == 9'h1e1) sel_next = avs_writedata[1:0];
  end

  // Shadow registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctl_reg <= 8'h00;
      rte_reg <= 8'h00;
      sel_reg <= 2'h0;
      age_reg <= 4'h0;
    end else begin
      ctl_reg <= ctl_next;
      rte_reg <= rte_next;
      sel_reg <= sel_next;
      age_reg <= age_next;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  wait_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  upper_zero_a: assert property (avs_readdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  pair_a_a: assert property (pecl_out_a0 == pecl_out_a1)
    else $error("pair A differs");
  pair_b_a: assert property (pecl_out_b0 == pecl_out_b1)
    else $error("pair B differs");
  bypass_tog_a: assert property (ok && ctl_reg[7] && !dir
    |=> pecl_out_a0 != $past(pecl_out_a0))
    else $error("bypass output not toggling");
  force_lvl_a: assert property (ok && ctl_reg[7:6] == 2'b01 && !dir
    |-> pecl_out_a0 == ctl_reg[5])
    else $error("forced level wrong");
  direct_ref_a: assert property ((ok && dir && !sel_reg[1] && $stable(ref_level)) [*8]
    |-> pecl_out_a0 == ref_level)
    else $error("direct CLK route wrong");
  direct_vco_a: assert property ((ok && dir && sel_reg[1] && $stable(vco_level)) [*8]
    |-> pecl_out_a0 == vco_level)
    else $error("direct VCO route wrong");
endmodule

bind pdc_top pdc_checker u_pdc_checker (.clk(clk), .arst_n(arst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .vco_level(vco_level),
  .ref_level(ref_level), .pecl_out_a0(pecl_out_a0), .pecl_out_a1(pecl_out_a1),
  .pecl_out_b0(pecl_out_b0), .pecl_out_b1(pecl_out_b1));

// ===== testbench/pdc_top_tb.sv
// Self-checking bench of the PECL divider block
module pdc_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        rd = 1'b0, wr = 1'b0, align_n = 1'b1, vco = 1'b0, rf = 1'b0, dv = 1'b0;
  logic [8:0]  adr = 9'h0, b;
  logic [31:0] wd = 32'h0, rdat, sts;
  logic        wt, a0, a1, b0, b1, t;
  logic [7:0]  mdl [int];
  int          num_errors = 0, cmp_count = 0, seed = 32'h037955cc;
  int          n, lo, hi, eh, el, ph, nr [2];
  wire         pin = dv ? b0 : a0;

  pdc_top u_pdc_top (.clk(clk), .arst_n(arst_n), .avs_address(adr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wd), .avs_readdata(rdat), .avs_waitrequest(wt),
    .align_n(align_n), .vco_level(vco), .ref_level(rf), .pecl_out_a0(a0),
    .pecl_out_a1(a1), .pecl_out_b0(b0), .pecl_out_b1(b1));

  // Clock at 10 MHz
  always #50 clk = ~clk;

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One Avalon access, held until waitrequest is seen low; read data taken at that edge
  task automatic bus(input logic we, input logic [8:0] a, input logic [7:0] d,
                     output logic [31:0] q);
    adr <= a;
    wd <= {24'h0, d};
    wr <= we;
    rd <= !we;
    do @(posedge clk); while (wt !== 1'b0);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask

  // Write; the model ignores places it does not hold
  task automatic w(input logic [8:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
    if (mdl.exists(a)) mdl[a] = d;
  endtask

  // Read back against the model; unmapped places read zero
  task automatic r(input logic [8:0] a);
    logic [31:0] q;
    bus(1'b0, a, 8'h0, q);
    chk(q, mdl.exists(a) ? mdl[a] : 8'h0);
  endtask

  // Length of the next full run of one level on the watched pin
  task automatic run_len(input logic lvl, output int k);
    k = 0;
    while (pin === lvl) @(posedge clk);
    while (pin !== lvl) @(posedge clk);
    while (pin === lvl) begin
      @(posedge clk);
      k++;
    end
  endtask

  task automatic finish_test;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Watchdog far beyond the thousand or so cycles the run needs
  initial begin
    #2000000;
    num_errors++;
    finish_test();
  end

  initial begin
    for (int k = 0; k < 6; k++) mdl[9'h190 + k] = (k % 3 == 0) ? 8'h11 : 8'h00;
    mdl[9'h1e1] = 8'h00;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    // Reset values, then a write to an unmapped place
    foreach (mdl[k]) r(9'(k));
    w(9'h1a0, 8'h5a);
    r(9'h1a0);
    // Divider runs on both channels, correction off then on
    for (int i = 0; i < 4; i++) begin
      dv = i[0];
      b = dv ? 9'h193 : 9'h190;
      lo = 1 + {$random(seed)} % 15;
      hi = 1 + {$random(seed)} % 15;
      w(b, 8'(lo * 16 + hi));
      w(b + 9'h1, 8'h00);
      w(b + 9'h2, {7'h0, !i[1]});
      for (int k = 0; k < 3; k++) r(b + 9'(k));
      repeat (2) begin
        run_len(1'b1, eh);
        run_len(1'b0, el);
      end
      chk(eh, i[1] ? (lo + hi + 1) / 2 : hi);
      chk(el, i[1] ? lo + hi - (lo + hi + 1) / 2 : lo);
    end
    // Alignment: B obeys, A ignores it and is forced to the other level
    w(9'h193, 8'h44);
    w(9'h195, 8'h01);
    for (int p = 0; p < 2; p++) begin
      ph = 1 + {$random(seed)} % 15;
      w(9'h191, {2'b01, !p[0], 5'h0});
      for (int q = 0; q < 2; q++) begin
        w(9'h194, {3'b000, p[0], q ? ph[3:0] : 4'h0});
        align_n <= 1'b0;
        repeat (10) @(posedge clk);
        chk(b0, p[0]);
        chk(a0, !p[0]);
        // Status while aligned: alignment seen, both held, pins at their levels
        bus(1'b0, 9'h1f0, 8'h00, sts);
        chk(sts, p[0] ? 32'h00000005 : 32'h00000003);
        align_n <= 1'b1;
        n = 0;
        while (b0 === p[0]) begin
          @(posedge clk);
          n++;
        end
        nr[q] = n;
      end
      chk(nr[1] - nr[0], ph);
    end
    // Bypass under select codes 1 and 3, direct route on CLK and VCO under codes 0 and 2
    w(9'h191, 8'h80);
    w(9'h192, 8'h02);
    for (int s = 0; s < 4; s++) begin
      w(9'h1e1, 8'(s));
      {vco, rf} <= 2'($random(seed));
      repeat (20) @(posedge clk);
      t = a0;
      @(posedge clk);
      chk(a0, s == 2 ? vco : s == 0 ? rf : !t);
    end
    finish_test();
  end
endmodule
